// [scan_host.sv]
// Purpose: Debugger model driving the scan chain
// Assumes: Test clock runs only while a frame, a readback or a test reset is stepped
// Notes: Data shifted least significant bit first
`timescale 1ns/100ps
module scan_host
(
	// Test access port drive
	output logic o_tck,
	output logic o_trst_n,
	output logic o_tdi,
	output logic o_shift,
	output logic o_capture,
	output logic o_update,
	// Scan return
	input wire logic i_tdo
);
	logic [37:0] sr;
	// Idle levels, test reset over two edges
	initial
	begin
		{o_tck, o_tdi, o_shift, o_capture, o_update, o_trst_n} = 6'h00;
		#7;
		repeat (2) step(4'h0);
		o_trst_n = 1'b1;
	end
	// One gated test clock period, levels {shift,capture,update,tdi}
	task automatic step(input logic [3:0] v);
		{o_shift, o_capture, o_update, o_tdi} = v;
		#40 o_tck = 1'b1;
		#40 o_tck = 1'b0;
	endtask
	// Full frame then update
	task automatic frame(input logic [37:0] f);
		sr = f;
		for (int i = 0; i < 38; i++)
			step({3'h4, sr[i]});
		step(4'h2);
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		frame({1'h1, a, d});
	endtask
	// Junk data field must not be written
	task automatic rd(input logic [4:0] a, output logic [31:0] q);
		frame({1'h0, a, 32'ha5a5a5a5});
		step(4'h4);
		for (int i = 0; i < 32; i++)
		begin
			q[i] = i_tdo;
			step(4'h8);
		end
	endtask
	// Test reset pulse over one gated edge
	task automatic treset;
		o_trst_n = 1'b0;
		step(4'h0);
		o_trst_n = 1'b1;
	endtask
endmodule // scan_host

// [tb.sv]
// Purpose: Self-checking bench for the comparator units
// Assumes: Registers settle within eight core cycles
// Notes: Bus codes are {write,size,access_protection_field,pabt,dabt,expect}
`timescale 1ns/100ps
module tb;
	logic clk = 1'b0, rst_n = 1'b0, tck, trst_n, tdi, sh, cap, upd, tdo;
	logic val = 1'b0, w = 1'b0, rq = 1'b0, pa = 1'b0, da = 1'b0, irq = 1'b0, ex = 1'b0;
	logic [31:0] ad = 32'h0, q;
	logic [1:0] sz = 2'h0, pr = 2'h0;
	logic brk, dbg, bf, mf, idis, exm, irem, arem;
	logic cl, rl;
	logic er = 1'b1;
	logic [1:0] xc = 2'h0;
	logic [31:0] dt = 32'h0;
	int failures = 0;
	int compares = 0;
	// Core clock
	always #20 clk = ~clk;
	scan_host u_host (.o_tck(tck), .o_trst_n(trst_n), .o_tdi(tdi), .o_shift(sh), .o_capture(cap),
		.o_update(upd), .i_tdo(tdo));
	watchpoint_comparator_unit u_dut (.i_clk(clk), .i_resetn(rst_n), .i_tck(tck), .i_debug_test_reset_n(trst_n),
		.i_tdi(tdi), .i_shift_dr(sh), .i_capture_dr(cap), .i_update_dr(upd), .o_tdo(tdo), .i_bus_valid(val),
		.i_bus_addr(ad), .i_bus_data(dt), .i_bus_write(w), .i_bus_size(sz), .i_access_protection_field(pr),
		.i_external_condition_in(xc), .i_debug_request_in(rq), .i_prefetch_abort(pa), .i_data_abort(da),
		.i_irq_pending(irq), .i_debug_exit(ex), .o_break_request(brk), .o_in_debug(dbg),
		.o_break_match_flag(bf), .o_debug_entry_mode_flag(mf), .o_irq_disable(idis),
		.o_enter_exception_mode(exm), .o_irq_remembered(irem), .o_abort_remembered(arem),
		.o_chain_link_out(cl), .o_range_link_out(rl));
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			failures++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic final_report;
		if (failures == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// One bus cycle; break request checked 5 ns after the inputs are driven
	task automatic bus(input logic [31:0] a, input logic [7:0] c);
		@(posedge clk);
		#1 {val, ad, w, sz, pr, pa, da} = {1'h1, a, c[7:1]};
		#5 chk("break_request", 32'(c[0]), 32'(brk));
		chk("range_link", 32'(er), 32'(rl));
		@(posedge clk);
		#1 {val, pa, da} = 3'h0;
	endtask
	task automatic leave;
		@(posedge clk);
		#1 ex = 1'b1;
		@(posedge clk);
		#1 ex = 1'b0;
		chk("left", 32'h0, 32'(dbg));
	endtask
	// Main sequence
	initial
	begin
		repeat (10) @(posedge clk);
		#1 rst_n = 1'b1;
		u_host.rd(wp_pkg::RA_U0_AM, q);
		chk("am_reset", 32'hffffffff, q);
		u_host.rd(wp_pkg::RA_U0_CV, q);
		chk("cv_reset", 32'h0, q);
		u_host.wr(wp_pkg::RA_U0_AV, 32'h00000100);
		u_host.wr(wp_pkg::RA_U0_AM, 32'h0);
		u_host.wr(wp_pkg::RA_U0_CV, 32'h0000010d);
		u_host.wr(wp_pkg::RA_U0_CM, 32'h000000f0);
		u_host.rd(wp_pkg::RA_U0_AV, q);
		chk("av", 32'h00000100, q);
		u_host.rd(wp_pkg::RA_U0_CV, q);
		chk("cv", 32'h0000010d, q);
		u_host.rd(wp_pkg::RA_U0_CM, q);
		chk("cm", 32'h000000f0, q);
		u_host.rd(5'h1f, q);
		chk("unmapped", 32'h0, q);
		repeat (8) @(posedge clk);
		bus(32'h00000100, 8'h48);
		bus(32'h00000100, 8'ha8);
		bus(32'h00000100, 8'he8);
		bus(32'h00000100, 8'hc0);
		bus(32'h00000104, 8'hc8);
		irq = 1'b1;
		bus(32'h00000100, 8'hdb);
		chk("wp_entry", 32'h1b, {27'h0, dbg, bf, mf, idis, irem});
		chk("abort_kept", 32'h3, {30'h0, arem, exm});
		irq = 1'b0;
		u_host.rd(wp_pkg::RA_STATUS, q);
		chk("status_wp", 32'h1, q & 32'h00001001);
		leave();
		@(posedge clk);
		#1 rq = 1'b1;
		@(posedge clk);
		#1 rq = 1'b0;
		chk("req_entry", 32'h7, {29'h0, dbg, mf, idis});
		u_host.rd(wp_pkg::RA_STATUS, q);
		chk("status_req", 32'h1, 32'(q[12]));
		leave();
		u_host.wr(wp_pkg::RA_U0_CV, 32'h00000100);
		u_host.wr(wp_pkg::RA_U0_CM, 32'h000000f7);
		repeat (8) @(posedge clk);
		bus(32'h00000100, 8'h04);
		bus(32'h00000100, 8'h01);
		chk("bp_entry", 32'h4, {29'h0, dbg, bf, mf});
		leave();
		u_host.wr(wp_pkg::RA_U0_CV, 32'h0);
		repeat (8) @(posedge clk);
		bus(32'h00000100, 8'h00);
		// Unit 1 data watch gated by external bit 1, its range arming unit 0
		u_host.wr(wp_pkg::RA_U1_AV, 32'h00000200);
		u_host.wr(wp_pkg::RA_U1_AM, 32'h0);
		u_host.wr(wp_pkg::RA_U1_DV, 32'h00000055);
		u_host.wr(wp_pkg::RA_U1_DM, 32'h0);
		u_host.wr(wp_pkg::RA_U1_CM, 32'h000000d0);
		chk("chain_set", 32'h1, 32'(cl));
		u_host.wr(wp_pkg::RA_U1_CV, 32'h0000002c);
		u_host.wr(wp_pkg::RA_U0_AM, 32'hffffffff);
		u_host.wr(wp_pkg::RA_U0_CV, 32'h00000180);
		u_host.wr(wp_pkg::RA_U0_CM, 32'h0000007f);
		xc = 2'h2;
		er = 1'b0;
		repeat (8) @(posedge clk);
		#1 dt = 32'h00000054;
		chk("chain_clear", 32'h0, 32'(cl));
		bus(32'h00000200, 8'h48);
		dt = 32'h00000055;
		er = 1'b1;
		bus(32'h00000200, 8'h49);
		chk("chain_load", 32'h1, 32'(cl));
		chk("range_entry", 32'h1, 32'(dbg));
		leave();
		xc = 2'h0;
		er = 1'b0;
		repeat (4) @(posedge clk);
		bus(32'h00000200, 8'h48);
		chk("chain_hold", 32'h1, 32'(cl));
		u_host.treset();
		repeat (8) @(posedge clk);
		chk("chain_trst", 32'h0, 32'(cl));
		final_report();
	end
	// Watchdog
	initial
	begin
		#300000;
		failures++;
		final_report();
	end
endmodule // tb

// [watchpoint_comparator_unit.sv]
// Purpose: Two watchpoint comparator units with scan-chain register access
// Assumes: Debugger keeps its own ordering and return-branch duties
// Notes: Chain logic on the test clock, comparators on the core clock.
//  The register bank reaches the core through a toggle handshake, so two
//  scan writes must lie at least four core cycles apart; a full frame does.
// Contract
// - Report entry cause via break and mode flags
// - Prefetch abort beats breakpoint
// - Debug entry disables interrupts
// - Pending interrupt: enter in its mode, remember
// - Watchpoint with data abort: abort mode, retained
// - Two units, address/data/control value-mask pairs
// - 38-bit chain: data, address, read/write bit
// - Write with rw 1, read with rw 0
// - Access takes effect on update-DR state
// - Set mask bit forces bit match
// - Control value and mask share layout
// - Unmaskable enable gates break request
// - Direction bit compares core write signal
// - Size field compares core size
// - Protection bits: fetch/data and user/privileged
// - External condition bit per unit
// - Unit 1 chain register feeds unit 0
// - Unit 1 range output feeds unit 0
`timescale 1ns/100ps
module watchpoint_comparator_unit
(
	// Core clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// Test access port
	input wire logic i_tck,
	input wire logic i_debug_test_reset_n,
	input wire logic i_tdi,
	input wire logic i_shift_dr,
	input wire logic i_capture_dr,
	input wire logic i_update_dr,
	output logic o_tdo,
	// Core bus activity
	input wire logic i_bus_valid,
	input wire logic [31:0] i_bus_addr,
	input wire logic [31:0] i_bus_data,
	input wire logic i_bus_write,
	input wire logic [1:0] i_bus_size,
	input wire logic [1:0] i_access_protection_field,
	input wire logic [1:0] i_external_condition_in,
	input wire logic i_debug_request_in,
	input wire logic i_prefetch_abort,
	input wire logic i_data_abort,
	input wire logic i_irq_pending,
	input wire logic i_debug_exit,
	// Debug status
	output logic o_break_request,
	output logic o_in_debug,
	output logic o_break_match_flag,
	output logic o_debug_entry_mode_flag,
	output logic o_irq_disable,
	output logic o_enter_exception_mode,
	output logic o_irq_remembered,
	output logic o_abort_remembered,
	output logic o_chain_link_out,
	output logic o_range_link_out
);
	localparam int DW = wp_pkg::DATA_W;

	// Registers in the test clock domain
	logic [wp_pkg::CHAIN_LEN-1:0] chain_q;
	logic [DW-1:0] av_q [2];
	logic [DW-1:0] am_q [2];
	logic [DW-1:0] dv_q [2];
	logic [DW-1:0] dm_q [2];
	logic [wp_pkg::CTRL_W-1:0] match_control_value_q [2];
	logic [wp_pkg::CMASK_W-1:0] match_control_mask_q [2];
	logic cv_wr_tgl_q;
	logic bank_tgl_q;
	logic [wp_pkg::ADDR_W-1:0] acc_addr;
	logic acc_rw;
	logic [DW-1:0] rd_data;
	logic [DW-1:0] status_word;

	// Core domain registers
	logic [1:0] ext_s1_q, ext_s2_q;
	logic cvw_s1_q, cvw_s2_q, cvw_s3_q;
	logic bank_s1_q, bank_s2_q, bank_s3_q;
	logic trst_s1_q, trst_s2_q, reload_q;
	// Core copy of the register bank
	logic [DW-1:0] av_c_q [2];
	logic [DW-1:0] am_c_q [2];
	logic [DW-1:0] dv_c_q [2];
	logic [DW-1:0] dm_c_q [2];
	logic [wp_pkg::CTRL_W-1:0] cv_c_q [2];
	logic [wp_pkg::CMASK_W-1:0] cm_c_q [2];
	logic mode_s1_q, mode_s2_q, brk_s1_q, brk_s2_q;
	logic in_debug_q, brk_flag_q, mode_flag_q, irq_mem_q, abt_mem_q, chain_q1;
	logic [1:0] hit;
	logic [1:0] ac_hit;
	logic [1:0] d_hit;
	logic [1:0] rng;

	assign acc_addr = chain_q[wp_pkg::FLD_ADDR_LSB +: wp_pkg::ADDR_W];
	assign acc_rw = chain_q[wp_pkg::FLD_RW];

	// Status word read back through the chain
	always_comb
	begin
		status_word = '0;
		status_word[wp_pkg::ST_BREAK_BIT] = brk_s2_q;
		status_word[wp_pkg::ST_MODE_BIT] = mode_s2_q;
	end

	// Read multiplexer
	always_comb
	begin
		unique case (acc_addr)
			wp_pkg::RA_STATUS: rd_data = status_word;
			wp_pkg::RA_U0_AV: rd_data = av_q[0];
			wp_pkg::RA_U0_AM: rd_data = am_q[0];
			wp_pkg::RA_U0_DV: rd_data = dv_q[0];
			wp_pkg::RA_U0_DM: rd_data = dm_q[0];
			wp_pkg::RA_U0_CV: rd_data = DW'(match_control_value_q[0]);
			wp_pkg::RA_U0_CM: rd_data = DW'(match_control_mask_q[0]);
			wp_pkg::RA_U1_AV: rd_data = av_q[1];
			wp_pkg::RA_U1_AM: rd_data = am_q[1];
			wp_pkg::RA_U1_DV: rd_data = dv_q[1];
			wp_pkg::RA_U1_DM: rd_data = dm_q[1];
			wp_pkg::RA_U1_CV: rd_data = DW'(match_control_value_q[1]);
			wp_pkg::RA_U1_CM: rd_data = DW'(match_control_mask_q[1]);
			default: rd_data = '0;
		endcase
	end

	// Scan shift register: capture read data, shift toward tdo
	always_ff @(posedge i_tck)
	begin
		if (!i_debug_test_reset_n)
			chain_q <= '0;
		else if (i_capture_dr)
			chain_q <= {acc_rw, acc_addr, rd_data};
		else if (i_shift_dr)
			chain_q <= {i_tdi, chain_q[wp_pkg::CHAIN_LEN-1:1]};
	end

	assign o_tdo = chain_q[0];

	// Register writes on update-DR with rw set
	always_ff @(posedge i_tck)
	begin
		if (!i_debug_test_reset_n)
		begin
			for (int u = 0; u < 2; u++)
			begin
				av_q[u] <= '0;
				am_q[u] <= '1;
				dv_q[u] <= '0;
				dm_q[u] <= '1;
				match_control_value_q[u] <= '0;
				match_control_mask_q[u] <= '1;
			end
			cv_wr_tgl_q <= 1'b0;
			bank_tgl_q <= 1'b0;
		end
		else if (i_update_dr && acc_rw)
		begin
			bank_tgl_q <= ~bank_tgl_q;
			unique case (acc_addr)
				wp_pkg::RA_U0_AV: av_q[0] <= chain_q[DW-1:0];
				wp_pkg::RA_U0_AM: am_q[0] <= chain_q[DW-1:0];
				wp_pkg::RA_U0_DV: dv_q[0] <= chain_q[DW-1:0];
				wp_pkg::RA_U0_DM: dm_q[0] <= chain_q[DW-1:0];
				wp_pkg::RA_U0_CV: match_control_value_q[0] <= chain_q[wp_pkg::CTRL_W-1:0];
				wp_pkg::RA_U0_CM: match_control_mask_q[0] <= chain_q[wp_pkg::CMASK_W-1:0];
				wp_pkg::RA_U1_AV: av_q[1] <= chain_q[DW-1:0];
				wp_pkg::RA_U1_AM: am_q[1] <= chain_q[DW-1:0];
				wp_pkg::RA_U1_DV: dv_q[1] <= chain_q[DW-1:0];
				wp_pkg::RA_U1_DM: dm_q[1] <= chain_q[DW-1:0];
				wp_pkg::RA_U1_CV:
				begin
					match_control_value_q[1] <= chain_q[wp_pkg::CTRL_W-1:0];
					cv_wr_tgl_q <= ~cv_wr_tgl_q;
				end
				wp_pkg::RA_U1_CM: match_control_mask_q[1] <= chain_q[wp_pkg::CMASK_W-1:0];
				default: ;
			endcase
		end
	end

	// Synchronisers into the core domain
	always_ff @(posedge i_clk)
	begin
		if (!i_resetn)
		begin
			ext_s1_q <= '0;
			ext_s2_q <= '0;
			cvw_s1_q <= 1'b0;
			cvw_s2_q <= 1'b0;
			cvw_s3_q <= 1'b0;
			bank_s1_q <= 1'b0;
			bank_s2_q <= 1'b0;
			bank_s3_q <= 1'b0;
			trst_s1_q <= 1'b1;
			trst_s2_q <= 1'b1;
		end
		else
		begin
			ext_s1_q <= i_external_condition_in;
			ext_s2_q <= ext_s1_q;
			cvw_s1_q <= cv_wr_tgl_q;
			cvw_s2_q <= cvw_s1_q;
			cvw_s3_q <= cvw_s2_q;
			bank_s1_q <= bank_tgl_q;
			bank_s2_q <= bank_s1_q;
			bank_s3_q <= bank_s2_q;
			trst_s1_q <= i_debug_test_reset_n;
			trst_s2_q <= trst_s1_q;
		end
	end

	// Synchronisers into the test clock domain for status read
	always_ff @(posedge i_tck)
	begin
		if (!i_debug_test_reset_n)
		begin
			mode_s1_q <= 1'b0;
			mode_s2_q <= 1'b0;
			brk_s1_q <= 1'b0;
			brk_s2_q <= 1'b0;
		end
		else
		begin
			mode_s1_q <= mode_flag_q;
			mode_s2_q <= mode_s1_q;
			brk_s1_q <= brk_flag_q;
			brk_s2_q <= brk_s1_q;
		end
	end

	// One-shot reload of the core copy after a core reset
	always_ff @(posedge i_clk)
	begin
		if (!i_resetn)
			reload_q <= 1'b1;
		else
			reload_q <= 1'b0;
	end

	// Core copy of the bank: reset values under test reset, else refreshed
	// once a write toggle has crossed; the bank is stable by then because
	// the toggle flips on the same test clock edge as the data
	always_ff @(posedge i_clk)
	begin
		if (!i_resetn || !trst_s2_q)
		begin
			for (int u = 0; u < 2; u++)
			begin
				av_c_q[u] <= '0;
				am_c_q[u] <= '1;
				dv_c_q[u] <= '0;
				dm_c_q[u] <= '1;
				cv_c_q[u] <= '0;
				cm_c_q[u] <= '1;
			end
		end
		else if (reload_q || (bank_s2_q != bank_s3_q))
		begin
			for (int u = 0; u < 2; u++)
			begin
				av_c_q[u] <= av_q[u];
				am_c_q[u] <= am_q[u];
				dv_c_q[u] <= dv_q[u];
				dm_c_q[u] <= dm_q[u];
				cv_c_q[u] <= match_control_value_q[u];
				cm_c_q[u] <= match_control_mask_q[u];
			end
		end
	end

	// Comparator units on the core copy of the bank
	always_comb
	begin
		logic [wp_pkg::CTRL_W-1:0] in_c;
		logic [wp_pkg::CMASK_W-1:0] c_ok;
		in_c = '0;
		c_ok = '0;
		rng = '0;
		for (int u = 1; u >= 0; u--)
		begin
			in_c = '0;
			in_c[wp_pkg::CB_WRITE] = i_bus_write;
			in_c[wp_pkg::CB_SIZE1:wp_pkg::CB_SIZE0] = i_bus_size;
			in_c[wp_pkg::CB_PROT1:wp_pkg::CB_PROT0] = i_access_protection_field;
			in_c[wp_pkg::CB_EXT] = ext_s2_q[u];
			in_c[wp_pkg::CB_CHAIN] = (u == 0) ? chain_q1 : 1'b0;
			in_c[wp_pkg::CB_RANGE] = (u == 0) ? rng[1] : 1'b0;
			c_ok = ~(in_c[wp_pkg::CMASK_W-1:0] ^ cv_c_q[u][wp_pkg::CMASK_W-1:0])
				| cm_c_q[u];
			d_hit[u] = &(~(i_bus_data ^ dv_c_q[u]) | dm_c_q[u]);
			ac_hit[u] = (&(~(i_bus_addr ^ av_c_q[u]) | am_c_q[u])) && (&c_ok) && i_bus_valid;
			rng[u] = ac_hit[u] && d_hit[u];
			hit[u] = rng[u] && cv_c_q[u][wp_pkg::CB_ENABLE];
		end
	end

	assign o_range_link_out = rng[1];

	// Chain register of unit 1: test reset clears, a match load beats a write clear
	always_ff @(posedge i_clk)
	begin
		if (!i_resetn || !trst_s2_q)
			chain_q1 <= 1'b0;
		else if (ac_hit[1])
			chain_q1 <= d_hit[1];
		else if (cvw_s2_q != cvw_s3_q)
			chain_q1 <= 1'b0;
	end

	assign o_chain_link_out = chain_q1;

	// Debug entry, cause flags and exception priority
	always_ff @(posedge i_clk)
	begin
		if (!i_resetn)
		begin
			in_debug_q <= 1'b0;
			brk_flag_q <= 1'b0;
			mode_flag_q <= 1'b0;
			irq_mem_q <= 1'b0;
			abt_mem_q <= 1'b0;
		end
		else if (in_debug_q)
		begin
			if (i_debug_exit)
				in_debug_q <= 1'b0;
		end
		else if (i_debug_request_in)
		begin
			in_debug_q <= 1'b1;
			mode_flag_q <= 1'b1;
			brk_flag_q <= 1'b0;
			irq_mem_q <= i_irq_pending;
			abt_mem_q <= 1'b0;
		end
		else if (|hit)
		begin
			if (i_access_protection_field[0])
			begin
				in_debug_q <= 1'b1;
				mode_flag_q <= 1'b0;
				brk_flag_q <= 1'b1;
				abt_mem_q <= i_data_abort;
				irq_mem_q <= i_irq_pending;
			end
			else if (!i_prefetch_abort)
			begin
				in_debug_q <= 1'b1;
				mode_flag_q <= 1'b0;
				brk_flag_q <= 1'b0;
				abt_mem_q <= 1'b0;
				irq_mem_q <= i_irq_pending;
			end
		end
	end

	// Break request when not blocked by a prefetch abort
	assign o_break_request = (|hit) && !(i_prefetch_abort && !i_access_protection_field[0]);
	assign o_in_debug = in_debug_q;
	assign o_irq_disable = in_debug_q;
	assign o_break_match_flag = brk_flag_q;
	assign o_debug_entry_mode_flag = mode_flag_q;
	assign o_irq_remembered = irq_mem_q;
	assign o_abort_remembered = abt_mem_q;
	assign o_enter_exception_mode = in_debug_q && (irq_mem_q || abt_mem_q);
endmodule // watchpoint_comparator_unit

// [wp_pkg.sv]
// Purpose: Shared constants for the watchpoint comparator unit
// Assumes: Scan chain register addresses are chosen locally
// Notes: Control layout as used by both comparator units
package wp_pkg;
	localparam int CHAIN_LEN = 38;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 5;
	localparam int CTRL_W = 9;
	localparam int CMASK_W = 8;
	// Chain field positions
	localparam int FLD_DATA_LSB = 0;
	localparam int FLD_ADDR_LSB = 32;
	localparam int FLD_RW = 37;
	// Control field bits
	localparam int CB_WRITE = 0;
	localparam int CB_SIZE0 = 1;
	localparam int CB_SIZE1 = 2;
	localparam int CB_PROT0 = 3;
	localparam int CB_PROT1 = 4;
	localparam int CB_EXT = 5;
	localparam int CB_CHAIN = 6;
	localparam int CB_RANGE = 7;
	localparam int CB_ENABLE = 8;
	// Register addresses within the chain address field
	localparam logic [4:0] RA_STATUS = 5'h01;
	localparam logic [4:0] RA_U0_AV = 5'h08;
	localparam logic [4:0] RA_U0_AM = 5'h09;
	localparam logic [4:0] RA_U0_DV = 5'h0a;
	localparam logic [4:0] RA_U0_DM = 5'h0b;
	localparam logic [4:0] RA_U0_CV = 5'h0c;
	localparam logic [4:0] RA_U0_CM = 5'h0d;
	localparam logic [4:0] RA_U1_AV = 5'h10;
	localparam logic [4:0] RA_U1_AM = 5'h11;
	localparam logic [4:0] RA_U1_DV = 5'h12;
	localparam logic [4:0] RA_U1_DM = 5'h13;
	localparam logic [4:0] RA_U1_CV = 5'h14;
	localparam logic [4:0] RA_U1_CM = 5'h15;
	// Status register bit for the entry mode flag
	localparam int ST_MODE_BIT = 12;
	// Status register bit mirroring the break flag
	localparam int ST_BREAK_BIT = 0;
endpackage

// [wp_props.sv]
// Purpose: Checks debug entry cause, priorities and hold
// Assumes: Core clock domain only
// Notes: Bound to the top module below
`timescale 1ns/100ps
module wp_props
(
	// Core clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// Core side inputs
	input wire logic i_bus_valid,
	input wire logic [1:0] i_access_protection_field,
	input wire logic i_debug_request_in,
	input wire logic i_prefetch_abort,
	input wire logic i_data_abort,
	input wire logic i_irq_pending,
	input wire logic i_debug_exit,
	// Debug status outputs
	input wire logic o_break_request,
	input wire logic o_in_debug,
	input wire logic o_break_match_flag,
	input wire logic o_debug_entry_mode_flag,
	input wire logic o_irq_disable,
	input wire logic o_irq_remembered,
	input wire logic o_abort_remembered
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_resetn);
	logic idle;
	// Free to enter debug this cycle
	assign idle = !o_in_debug && !i_debug_exit;
	property p_irq_off;
		idle && (o_break_request || i_debug_request_in) |=> o_irq_disable;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("irq not disabled in debug");
	property p_pabt;
		i_bus_valid && !i_access_protection_field[0] && i_prefetch_abort |-> !o_break_request;
	endproperty
	a_pabt: assert property (p_pabt) else $error("break despite prefetch abort");
	property p_go;
		idle && o_break_request |=> o_in_debug;
	endproperty
	a_go: assert property (p_go) else $error("break did not enter debug");
	property p_req;
		idle && i_debug_request_in |=> o_in_debug && o_debug_entry_mode_flag;
	endproperty
	a_req: assert property (p_req) else $error("request entry wrong");
	property p_wp;
		idle && o_break_request && !i_debug_request_in && i_access_protection_field[0]
			|=> o_break_match_flag && !o_debug_entry_mode_flag;
	endproperty
	a_wp: assert property (p_wp) else $error("watchpoint cause wrong");
	property p_irq;
		idle && (o_break_request || i_debug_request_in) && i_irq_pending |=> o_irq_remembered;
	endproperty
	a_irq: assert property (p_irq) else $error("pending irq lost");
	property p_abt;
		idle && o_break_request && i_data_abort && i_access_protection_field[0] |=> o_abort_remembered;
	endproperty
	a_abt: assert property (p_abt) else $error("data abort lost");
	property p_hold;
		o_in_debug && !i_debug_exit |=> o_in_debug && $stable(o_break_match_flag);
	endproperty
	a_hold: assert property (p_hold) else $error("debug state not held");
endmodule // wp_props
bind watchpoint_comparator_unit wp_props u_props (.i_clk(i_clk), .i_resetn(i_resetn), .i_bus_valid(i_bus_valid),
	.i_access_protection_field(i_access_protection_field), .i_debug_request_in(i_debug_request_in),
	.i_prefetch_abort(i_prefetch_abort), .i_data_abort(i_data_abort), .i_irq_pending(i_irq_pending),
	.i_debug_exit(i_debug_exit), .o_break_request(o_break_request), .o_in_debug(o_in_debug),
	.o_break_match_flag(o_break_match_flag), .o_debug_entry_mode_flag(o_debug_entry_mode_flag),
	.o_irq_disable(o_irq_disable), .o_irq_remembered(o_irq_remembered), .o_abort_remembered(o_abort_remembered));
